// ===== hw/tdf_bank.sv
// Purpose: status/control byte and alarm/warning flag bytes
// Assumes: host port is byte wide, pins synchronous to i_mclk
// Notes:   alarm and warning limits arrive as ports, order
//          temperature, supply, bias, transmit power, receive power
// Behaviour
// - status bit mirrors live level of the transmit-inhibit input pin
// - soft transmit-inhibit bit is writable and reads back
// - transmitter disabled when soft bit or pin is asserted
// - status bit mirrors the transmit-fault output level
// - status bit mirrors the receive_signal_loss output level
// - active-low ready bit reads 0 once powered and data valid
// - soft commands act and show within 100 ms
// - alarm byte one: temp 7/6, supply 5/4, bias 3/2, tx power 1/0
// - alarm byte two: rx power high bit 7, low bit 6, rest reserved
// - warning byte one mirrors alarm layout against warning limits
// - warning byte two: rx power high bit 7, low bit 6
// - high flag above high limit, low flag below low limit
// - status/control byte sits at offset 110
// - temperature compared as 16-bit signed two's complement
module tdf_bank #(
	parameter int W  = tdf_pkg::MEAS_W,
	parameter int NC = tdf_pkg::NUM_CH
) (
	// clock and reset
	input  wire logic                          i_mclk,
	input  wire logic                          i_rst,
	// register port
	input  wire logic [tdf_pkg::ADDR_W-1:0]    i_addr,
	input  wire logic [tdf_pkg::DATA_W-1:0]    i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic [tdf_pkg::DATA_W-1:0]         o_rdata,
	// module pins and status
	input  wire logic                          i_tx_inhibit_pin,
	input  wire logic                          i_tx_fault,
	input  wire logic                          i_receive_signal_loss,
	input  wire logic                          i_power_good,
	input  wire logic                          i_meas_valid,
	// measurement
	input  wire logic                          i_sample,
	input  wire logic [NC*W-1:0]               i_value,
	input  wire logic [NC*W-1:0]               i_alarm_high,
	input  wire logic [NC*W-1:0]               i_alarm_low,
	input  wire logic [NC*W-1:0]               i_warn_high,
	input  wire logic [NC*W-1:0]               i_warn_low,
	// outputs
	output logic                               o_tx_disable,
	output logic                               o_irq
);
	logic [NC-1:0] alarm_hi;
	logic [NC-1:0] alarm_lo;
	logic [NC-1:0] warn_hi;
	logic [NC-1:0] warn_lo;

	// two comparators per channel; channel 0 is temperature, signed
	generate
		for (genvar c = 0; c < NC; c++) begin : g_ch
			tdf_cmp #(.W(W), .SIGNED(c == 0)) u_alarm (
				.i_mclk  (i_mclk),
				.i_rst   (i_rst),
				.i_sample(i_sample),
				.i_value (i_value[c*W +: W]),
				.i_high  (i_alarm_high[c*W +: W]),
				.i_low   (i_alarm_low[c*W +: W]),
				.o_high  (alarm_hi[c]),
				.o_low   (alarm_lo[c])
			);
			tdf_cmp #(.W(W), .SIGNED(c == 0)) u_warn (
				.i_mclk  (i_mclk),
				.i_rst   (i_rst),
				.i_sample(i_sample),
				.i_value (i_value[c*W +: W]),
				.i_high  (i_warn_high[c*W +: W]),
				.i_low   (i_warn_low[c*W +: W]),
				.o_high  (warn_hi[c]),
				.o_low   (warn_lo[c])
			);
		end
	endgenerate

	// flag bytes
	logic [7:0] alarm_pri;
	logic [7:0] alarm_rx;
	logic [7:0] warn_pri;
	logic [7:0] warn_rx;

	assign alarm_pri = {alarm_hi[0], alarm_lo[0], alarm_hi[1], alarm_lo[1],
			alarm_hi[2], alarm_lo[2], alarm_hi[3], alarm_lo[3]};
	assign alarm_rx  = {alarm_hi[4], alarm_lo[4], 6'h00};
	assign warn_pri  = {warn_hi[0], warn_lo[0], warn_hi[1], warn_lo[1],
			warn_hi[2], warn_lo[2], warn_hi[3], warn_lo[3]};
	assign warn_rx   = {warn_hi[4], warn_lo[4], 6'h00};

	// address decode
	logic hit_sc;
	logic hit_ap;
	logic hit_ar;
	logic hit_wp;
	logic hit_wr;
	logic hit_is;
	logic hit_im;

	assign hit_sc = (i_addr == tdf_pkg::OFF_STATUS_CTRL);
	assign hit_ap = (i_addr == tdf_pkg::OFF_ALARM_PRI);
	assign hit_ar = (i_addr == tdf_pkg::OFF_ALARM_RX);
	assign hit_wp = (i_addr == tdf_pkg::OFF_WARN_PRI);
	assign hit_wr = (i_addr == tdf_pkg::OFF_WARN_RX);
	assign hit_is = (i_addr == tdf_pkg::OFF_IRQ_STATUS);
	assign hit_im = (i_addr == tdf_pkg::OFF_IRQ_MASK);

	// soft inhibit register
	logic soft_inh_q;
	logic soft_inh_d;

	assign soft_inh_d = (i_wr && hit_sc) ? i_wdata[tdf_pkg::SC_SOFT_INH]
			: soft_inh_q;

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			soft_inh_q <= 1'b0;
		else
			soft_inh_q <= soft_inh_d;
	end

	// transmit disable, registered: two cycles from write, well inside 100 ms
	logic tx_dis_q;

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			tx_dis_q <= 1'b1;
		else
			tx_dis_q <= soft_inh_q | i_tx_inhibit_pin;
	end

	assign o_tx_disable = tx_dis_q;

	// status/control byte
	logic       not_ready;
	logic [7:0] sc_byte;

	assign not_ready = ~(i_power_good & i_meas_valid);
	assign sc_byte   = {i_tx_inhibit_pin, soft_inh_q, 3'h0, i_tx_fault,
			i_receive_signal_loss, not_ready};

	// interrupt events
	logic [tdf_pkg::IRQ_W-1:0] ev;
	logic [tdf_pkg::IRQ_W-1:0] prev_q;
	logic [tdf_pkg::IRQ_W-1:0] lvl;
	logic [tdf_pkg::IRQ_W-1:0] ist_q;
	logic [tdf_pkg::IRQ_W-1:0] ist_d;
	logic [tdf_pkg::IRQ_W-1:0] imask_q;
	logic [tdf_pkg::IRQ_W-1:0] wclr;

	assign lvl[tdf_pkg::IRQ_ALARM]    = |{alarm_pri, alarm_rx};
	assign lvl[tdf_pkg::IRQ_WARN]     = |{warn_pri, warn_rx};
	assign lvl[tdf_pkg::IRQ_INHIBIT]  = tx_dis_q;
	assign lvl[tdf_pkg::IRQ_FAULT]    = i_tx_fault;
	assign lvl[tdf_pkg::IRQ_SIG_LOSS] = i_receive_signal_loss;
	assign lvl[tdf_pkg::IRQ_READY]    = ~not_ready;
	assign ev    = lvl & ~prev_q;
	assign wclr  = (i_wr && hit_is) ? i_wdata[tdf_pkg::IRQ_W-1:0] : '0;
	// set wins over a clear in the same cycle
	assign ist_d = (ist_q & ~wclr) | ev;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			// disable is high in reset: no false edge on release
			prev_q                       <= '0;
			prev_q[tdf_pkg::IRQ_INHIBIT] <= 1'b1;
			ist_q   <= '0;
			imask_q <= '0;
		end else begin
			prev_q  <= lvl;
			ist_q   <= ist_d;
			if (i_wr && hit_im)
				imask_q <= i_wdata[tdf_pkg::IRQ_W-1:0];
		end
	end

	assign o_irq = |(ist_q & imask_q);

	// read path
	logic [7:0] rd_mux;
	logic [7:0] rdata_q;

	assign rd_mux = hit_sc ? sc_byte :
			hit_ap ? alarm_pri :
			hit_ar ? alarm_rx :
			hit_wp ? warn_pri :
			hit_wr ? warn_rx :
			hit_is ? {2'h0, ist_q} :
			hit_im ? {2'h0, imask_q} : tdf_pkg::RESET_BYTE;

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			rdata_q <= tdf_pkg::RESET_BYTE;
		else if (i_rd)
			rdata_q <= rd_mux;
		else
			rdata_q <= tdf_pkg::RESET_BYTE;
	end

	assign o_rdata = rdata_q;

	logic hit_sc_q;

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			hit_sc_q <= 1'b0;
		else
			hit_sc_q <= hit_sc;
	end

	// checks
	a_soft_readback: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_wr && hit_sc ##1 i_rd && hit_sc |=>
		o_rdata[tdf_pkg::SC_SOFT_INH] == $past(i_wdata[tdf_pkg::SC_SOFT_INH], 2))
		else $error("soft inhibit readback wrong");
	a_pin_mirror: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && hit_sc |=> o_rdata[tdf_pkg::SC_PIN_INH] == $past(i_tx_inhibit_pin))
		else $error("pin inhibit not mirrored");
	a_tx_or: assert property (@(posedge i_mclk) disable iff (i_rst)
		(soft_inh_q | i_tx_inhibit_pin) |=> o_tx_disable)
		else $error("transmitter not disabled");
	a_tx_enable: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_tx_inhibit_pin && i_wr && hit_sc && !i_wdata[tdf_pkg::SC_SOFT_INH]
		##1 !i_tx_inhibit_pin |=> !o_tx_disable)
		else $error("soft command not applied");
	a_fault_loss: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && hit_sc |=> o_rdata[2:1] ==
		{$past(i_tx_fault), $past(i_receive_signal_loss)})
		else $error("fault or loss not mirrored");
	a_not_ready: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && hit_sc && i_power_good && i_meas_valid |=>
		!o_rdata[tdf_pkg::SC_NOT_READY])
		else $error("ready bit wrong");
	a_resv_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_rd && (hit_sc || hit_ar || hit_wr) |=>
		(hit_sc_q ? o_rdata[5:3] == 3'h0 : o_rdata[5:0] == 6'h00))
		else $error("reserved bits not zero");
	a_temp_high: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_sample && ($signed(i_value[W-1:0]) > $signed(i_alarm_high[W-1:0]))
		|=> alarm_pri[7])
		else $error("temperature high alarm missed");
	a_rx_low: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_sample && (i_warn_low[4*W +: W] > i_value[4*W +: W])
		|=> warn_rx[tdf_pkg::RX_LO_BIT] ##0 warn_pri == {warn_hi[0],
		warn_lo[0], warn_hi[1], warn_lo[1], warn_hi[2], warn_lo[2],
		warn_hi[3], warn_lo[3]})
		else $error("receive low warning missed");
	a_rx_alarm: assert property (@(posedge i_mclk) disable iff (i_rst)
		i_sample && (i_value[4*W +: W] > i_alarm_high[4*W +: W])
		|=> alarm_rx[tdf_pkg::RX_HI_BIT])
		else $error("receive high alarm missed");
	a_offset_sc: assert property (@(posedge i_mclk) disable iff (i_rst)
		hit_sc |-> i_addr == 8'h6e)
		else $error("status byte offset wrong");
endmodule

// ===== hw/tdf_cmp.sv
// Purpose: one monitored channel compared against high and low limits
// Assumes: thresholds held outside, values refreshed on i_sample
// Notes:   high flag on value above high, low flag on value below low
module tdf_cmp #(
	parameter int W      = 16,
	parameter bit SIGNED = 1'b0
) (
	// clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	// measurement
	input  wire logic         i_sample,
	input  wire logic [W-1:0] i_value,
	input  wire logic [W-1:0] i_high,
	input  wire logic [W-1:0] i_low,
	// flags
	output logic              o_high,
	output logic              o_low
);
	logic above;
	logic below;
	logic high_q;
	logic low_q;

	assign above = SIGNED ? ($signed(i_value) > $signed(i_high))
			: (i_value > i_high);
	assign below = SIGNED ? ($signed(i_value) < $signed(i_low))
			: (i_value < i_low);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			high_q <= 1'b0;
			low_q  <= 1'b0;
		end else if (i_sample) begin
			high_q <= above;
			low_q  <= below;
		end
	end

	assign o_high = high_q;
	assign o_low  = low_q;
endmodule

// ===== hw/tdf_pkg.sv
// Purpose: constants for the transceiver diagnostic status and flag bank
// Assumes: byte-wide register port, 20 MHz clock
// Notes:   offsets are byte addresses of the diagnostic page
package tdf_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 8;
	localparam int          MEAS_W          = 16;
	localparam int          NUM_CH          = 5;
	// register offsets
	localparam logic [7:0]  OFF_STATUS_CTRL = 8'h6e;
	localparam logic [7:0]  OFF_ALARM_PRI   = 8'h70;
	localparam logic [7:0]  OFF_ALARM_RX    = 8'h71;
	localparam logic [7:0]  OFF_WARN_PRI    = 8'h74;
	localparam logic [7:0]  OFF_WARN_RX     = 8'h75;
	localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h80;
	localparam logic [7:0]  OFF_IRQ_MASK    = 8'h81;
	// status/control byte fields
	localparam int          SC_PIN_INH      = 7;
	localparam int          SC_SOFT_INH     = 6;
	localparam int          SC_FAULT        = 2;
	localparam int          SC_SIG_LOSS     = 1;
	localparam int          SC_NOT_READY    = 0;
	// receive flag byte fields
	localparam int          RX_HI_BIT       = 7;
	localparam int          RX_LO_BIT       = 6;
	// interrupt status fields
	localparam int          IRQ_ALARM       = 0;
	localparam int          IRQ_WARN        = 1;
	localparam int          IRQ_INHIBIT     = 2;
	localparam int          IRQ_FAULT       = 3;
	localparam int          IRQ_SIG_LOSS    = 4;
	localparam int          IRQ_READY       = 5;
	localparam int          IRQ_W           = 6;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [7:0]  MASK_RESET      = 8'h00;
	// soft command response time
	localparam int          CMD_RESP_MS     = 100;
	localparam int          CLK_HZ          = 20_000_000;
	localparam longint      CMD_RESP_CYC    =
		(longint'(CMD_RESP_MS) * CLK_HZ) / 1000;
endpackage

// ===== test/tb_top.sv
// Purpose: self-checking bench for the diagnostic status and flag bank
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   each scenario but the read-only write check is a task that drives and judges
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr, wdata, rdata, d;
	logic        wr, rd, txdis, irq;
	logic        pin = 0, fault = 0, los = 0, pgood = 0, mvalid = 0;
	logic        sample = 0;
	logic [79:0] value = '0;
	logic [79:0] ah = {{4{16'h8000}}, 16'h1000};
	logic [79:0] al = {{4{16'h0100}}, 16'hf000};
	logic [79:0] wh = {{4{16'h4000}}, 16'h0800};
	logic [79:0] wl = {{4{16'h0200}}, 16'hf800};
	int          fail_count = 0;
	int          n_checks = 0;
	always #25 mclk = ~mclk;
	tdf_host_model host (.i_mclk(mclk), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd), .i_rdata(rdata));
	tdf_bank uut (.i_mclk(mclk), .i_rst(rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_tx_inhibit_pin(pin), .i_tx_fault(fault),
		.i_receive_signal_loss(los), .i_power_good(pgood),
		.i_meas_valid(mvalid), .i_sample(sample), .i_value(value),
		.i_alarm_high(ah), .i_alarm_low(al), .i_warn_high(wh),
		.i_warn_low(wl), .o_tx_disable(txdis), .o_irq(irq));
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic t_reset;
		host.rd(tdf_pkg::OFF_STATUS_CTRL, d);
		`CHK("status", 8'h01, d)
		@(posedge mclk); #1;
		`CHK("rdata idle", 8'h00, rdata)
		host.rd(8'h90, d);
		`CHK("unmapped", 8'h00, d)
		host.rd(tdf_pkg::OFF_IRQ_STATUS, d);
		`CHK("irq status rst", 8'h00, d)
		`CHK("txdis", 1'b0, txdis)
		`CHK("irq", 1'b0, irq)
	endtask
	task automatic t_pins;
		@(posedge mclk);
		{pin, fault, los, pgood, mvalid} <= 5'h1f;
		repeat (3) @(posedge mclk);
		host.rd(8'h6e, d);
		`CHK("pins", 8'h86, d)
		`CHK("txdis pin", 1'b1, txdis)
		{pin, fault, los} <= 3'h0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic t_soft;
		host.wr(tdf_pkg::OFF_STATUS_CTRL, 8'hff);
		@(posedge mclk); #1;
		`CHK("txdis soft", 1'b1, txdis)
		host.rd(tdf_pkg::OFF_STATUS_CTRL, d);
		`CHK("soft", 8'h40, d)
		host.wr(tdf_pkg::OFF_STATUS_CTRL, 8'h00);
		@(posedge mclk); #1;
		`CHK("txdis off", 1'b0, txdis)
	endtask
	task automatic t_flags(input logic [15:0] t, input logic [15:0] v,
		input logic [31:0] e);
		logic [31:0] g;
		@(posedge mclk);
		value <= {{4{v}}, t};
		sample <= 1'b1;
		@(posedge mclk);
		sample <= 1'b0;
		@(posedge mclk);
		host.rd(tdf_pkg::OFF_ALARM_PRI, g[31:24]);
		host.rd(tdf_pkg::OFF_ALARM_RX, g[23:16]);
		host.rd(tdf_pkg::OFF_WARN_PRI, g[15:8]);
		host.rd(tdf_pkg::OFF_WARN_RX, g[7:0]);
		`CHK("flags", e, g)
	endtask
	task automatic t_irq;
		host.wr(tdf_pkg::OFF_IRQ_MASK, 8'h00);
		host.wr(tdf_pkg::OFF_IRQ_STATUS, 8'h3f);
		host.rd(tdf_pkg::OFF_IRQ_STATUS, d);
		`CHK("irq clr", 8'h00, d)
		fault <= 1'b1;
		repeat (3) @(posedge mclk); #1;
		`CHK("irq masked", 1'b0, irq)
		host.rd(tdf_pkg::OFF_IRQ_STATUS, d);
		`CHK("irq fault", 8'h08, d)
		host.wr(tdf_pkg::OFF_IRQ_MASK, 8'h08);
		repeat (2) @(posedge mclk); #1;
		`CHK("irq on", 1'b1, irq)
		host.wr(tdf_pkg::OFF_IRQ_STATUS, 8'h08);
		repeat (2) @(posedge mclk); #1;
		`CHK("irq off", 1'b0, irq)
		fault <= 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		t_reset();
		t_pins();
		t_soft();
		t_flags(16'h2000, 16'h9000, 32'haa80aa80);
		t_flags(16'h0c00, 16'h5000, 32'h0000aa80);
		t_flags(16'hff00, 16'h1000, 32'h00000000);
		t_flags(16'he000, 16'h0050, 32'h55405540);
		t_flags(16'hf400, 16'h0150, 32'h00005540);
		host.wr(tdf_pkg::OFF_ALARM_PRI, 8'hff);
		host.rd(tdf_pkg::OFF_ALARM_PRI, d);
		`CHK("ro write", 8'h00, d)
		t_irq();
		results();
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#(5000 * 50);
		fail_count++;
		results();
	end
endmodule

// ===== test/tdf_host_model.sv
// Purpose: host controller driving the byte-wide register port
// Assumes: strobes one cycle, read data in the cycle after the strobe
// Notes:   tasks called from the bench; signals change after rising edge
module tdf_host_model (
	// clock
	input  wire logic       i_mclk,
	// register port
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata,
	output logic            o_wr,
	output logic            o_rd,
	input  wire logic [7:0] i_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_mclk);
		o_wr <= 1'b0;
	endtask
	// data taken in the single cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule
